// ### src/rsf_status_bank.sv
// Status register bank for two switching and two linear regulator channels.
`timescale 1ns/1ps
`include "rsf_defines.svh"
module rsf_status_bank
  import rsf_pkg::*;
#(
  parameter int NUM_BUCK = `RSF_NUM_BUCK,
  parameter int NUM_LIN = `RSF_NUM_LIN,
  parameter logic [`RSF_OC_CNT_W-1:0] OC_LIMIT = `RSF_OC_LIMIT_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic rd_req,
  input wire logic [`RSF_ADDR_W-1:0] rd_addr,
  input wire logic [NUM_BUCK-1:0] buck_on,
  input wire logic [NUM_BUCK-1:0] buck_ss_done,
  input wire logic [NUM_BUCK-1:0] buck_output_good,
  input wire logic [NUM_BUCK-1:0] buck_overcurrent_event,
  input wire logic [NUM_BUCK-1:0] buck_neg_limit_cmp,
  input wire logic [NUM_BUCK-1:0] buck_pulse_skip_mode,
  input wire logic [NUM_BUCK-1:0] buck_zero_cross_cmp,
  input wire logic [NUM_LIN-1:0] lin_on,
  input wire logic [NUM_LIN-1:0] lin_ss_done,
  input wire logic [NUM_LIN-1:0] lin_output_good,
  input wire logic [NUM_LIN-1:0] lin_current_limit,
  input wire logic [NUM_BUCK+NUM_LIN-1:0] fault_irq_mask,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic irq_out_n
);
  // ****************************************************************
  // Declarations.
  // ****************************************************************
  localparam int NUM_CHAN = NUM_BUCK + NUM_LIN; // Channels in register order.
  logic [7:0] chan_status [NUM_CHAN]; // Status byte per channel, buck channels first.
  logic [NUM_CHAN-1:0] chan_hit; // Read address selects this channel.
  logic [NUM_CHAN-1:0] chan_clear; // Clear-on-read pulse per channel.
  logic [NUM_CHAN-1:0] chan_fault; // Summary fault bit per channel.
  logic [`RSF_ADDR_W-1:0] chan_addr [NUM_CHAN]; // Offset per channel.
  rsf_top_state_t st; // Registered top state.
  rsf_top_state_t next_st; // Next top state.

  // ****************************************************************
  // Channel address map.
  // ****************************************************************
  // Offsets are consecutive, so a table keeps the decode in one loop.
  assign chan_addr[0] = `RSF_ADDR_BUCK3;
  assign chan_addr[1] = `RSF_ADDR_BUCK4;
  assign chan_addr[2] = `RSF_ADDR_LIN1;
  assign chan_addr[3] = `RSF_ADDR_LIN2;

  // ****************************************************************
  // Per-channel decode, clear pulse and fault tap.
  // ****************************************************************
  // The clear pulse lands on the same edge that captures the answer, so the
  // host sees the flag that caused the read before it goes.
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CHAN; gc++) begin : g_decode
      assign chan_hit[gc] = (rd_addr == chan_addr[gc]);
      assign chan_clear[gc] = rd_req && chan_hit[gc];
      assign chan_fault[gc] = chan_status[gc][`RSF_BIT_FAULT];
    end
  endgenerate

  // ****************************************************************
  // Switching channels.
  // ****************************************************************
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BUCK; gb++) begin : g_buck
      rsf_buck_channel #(
        .OC_LIMIT(OC_LIMIT)
      ) u_buck (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .regulator_on_status(buck_on[gb]),
        .soft_start_complete(buck_ss_done[gb]),
        .output_good(buck_output_good[gb]),
        .highside_overcurrent_event(buck_overcurrent_event[gb]),
        .neg_limit_cmp(buck_neg_limit_cmp[gb]),
        .pulse_skip_mode(buck_pulse_skip_mode[gb]),
        .zero_cross_cmp(buck_zero_cross_cmp[gb]),
        .clear_on_read(chan_clear[gb]),
        .status(chan_status[gb])
      );
    end
  endgenerate

  // ****************************************************************
  // Linear channels.
  // ****************************************************************
  genvar gl;
  generate
    for (gl = 0; gl < NUM_LIN; gl++) begin : g_lin
      rsf_lin_channel u_lin (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .regulator_on_status(lin_on[gl]),
        .soft_start_complete(lin_ss_done[gl]),
        .output_good(lin_output_good[gl]),
        .current_limit_live(lin_current_limit[gl]),
        .clear_on_read(chan_clear[NUM_BUCK+gl]),
        .status(chan_status[NUM_BUCK+gl])
      );
    end
  endgenerate

  // ****************************************************************
  // Read answer and interrupt line.
  // ****************************************************************
  // An unmapped offset answers zero rather than holding the old byte, so the
  // host never mistakes stale data for a flag.
  always_comb begin
    next_st = st;
    next_st.rd_valid = rd_req;
    if (rd_req) begin
      next_st.rd_data = `RSF_READ_ZERO;
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (chan_hit[i]) begin
          next_st.rd_data = chan_status[i];
        end
      end
    end
    // Any unmasked fault pulls the line low; it is a level, not a pulse.
    next_st.irq_out_n = ~|(chan_fault & ~fault_irq_mask);
  end

  // Register the top state; the interrupt line idles high.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{rd_data: `RSF_READ_ZERO, rd_valid: `RSF_VALID_IDLE, irq_out_n: `RSF_IRQ_IDLE};
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
  assign rd_valid = st.rd_valid;
  assign irq_out_n = st.irq_out_n;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  // Every read is answered on the very next edge, and only then.
  property p_answer;
    @(posedge clk_sys) disable iff (!rst_n) rd_req |=> rd_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("read not answered");

  // An unmasked fault drives the interrupt low one cycle later.
  property p_irq_low;
    @(posedge clk_sys) disable iff (!rst_n) |(chan_fault & ~fault_irq_mask) |=> !irq_out_n;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("unmasked fault left interrupt high");

  // A fully masked bank never asserts the interrupt.
  property p_irq_masked;
    @(posedge clk_sys) disable iff (!rst_n) !(|(chan_fault & ~fault_irq_mask)) |=> irq_out_n;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked fault asserted interrupt");

  // The reserved position of a switching channel always reads zero.
  property p_buck_reserved;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_req && rd_addr == `RSF_ADDR_BUCK3 |=> rd_data[`RSF_BIT_CUR_LIM] == 1'b0;
  endproperty
  a_buck_reserved: assert property (p_buck_reserved) else $error("buck reserved bit set");

  // Reserved positions of a linear channel always read zero.
  property p_lin_reserved;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_req && rd_addr == `RSF_ADDR_LIN1 |=> rd_data[`RSF_BIT_RETRY:`RSF_BIT_ZC] == 3'h0;
  endproperty
  a_lin_reserved: assert property (p_lin_reserved) else $error("linear reserved bits set");

  // Enabled, ramped and bad output raises the first buck fault, held through a read.
  sequence s_buck_bad;
    buck_on[0] && buck_ss_done[0] && !buck_output_good[0];
  endsequence
  property p_buck_fault;
    @(posedge clk_sys) disable iff (!rst_n) s_buck_bad |=> chan_fault[0];
  endproperty
  a_buck_fault: assert property (p_buck_fault) else $error("buck fault not set");

  // Live bits are sampled straight from the analogue side, read or not.
  property p_live_bits;
    @(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> chan_status[0][`RSF_BIT_ON] == $past(buck_on[0])
           && chan_status[0][`RSF_BIT_GOOD] == $past(buck_output_good[0])
           && chan_status[0][`RSF_BIT_SS_DONE] == $past(buck_ss_done[0]);
  endproperty
  a_live_bits: assert property (p_live_bits) else $error("live bit mismatch");

  // Linear current limit follows its input one cycle later.
  property p_lin_current_limit_live;
    @(posedge clk_sys) disable iff (!rst_n)
      lin_current_limit[0] |=> chan_status[NUM_BUCK][`RSF_BIT_CUR_LIM];
  endproperty
  a_lin_current_limit_live: assert property (p_lin_current_limit_live) else $error("linear current limit not shown");

  // A read with the cause gone clears the second linear fault, seen as two steps.
  sequence s_lin_read_clean;
    rd_req && rd_addr == `RSF_ADDR_LIN2 && chan_fault[NUM_BUCK+1]
      && !(lin_on[1] && lin_ss_done[1] && !lin_output_good[1]);
  endsequence
  sequence s_lin_cleared;
    ##1 !chan_fault[NUM_BUCK+1] && rd_data[`RSF_BIT_FAULT];
  endsequence
  property p_lin_clear;
    @(posedge clk_sys) disable iff (!rst_n) s_lin_read_clean |-> s_lin_cleared;
  endproperty
  a_lin_clear: assert property (p_lin_clear) else $error("linear fault not cleared by read");

  // ****************************************************************
  // Further checks on reads, sticky flags and the linear channels.
  // ****************************************************************
  // An answer never appears without a read on the edge before it.
  property p_valid_only;
    @(posedge clk_sys) disable iff (!rst_n) rd_valid |-> $past(rd_req);
  endproperty
  a_valid_only: assert property (p_valid_only) else $error("answer without a read");

  // A read returns the byte as it stood when the read was taken, before any clear.
  // Watching one channel is enough, since all channels share one capture path.
  property p_read_data;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_req && chan_hit[0] |=> rd_data == $past(chan_status[0]);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read returned wrong byte");

  // An offset outside the map answers zero, so stale bytes cannot look like flags.
  property p_unmapped;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_req && !(|chan_hit) |=> rd_data == `RSF_READ_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // The first linear channel shows its live inputs one cycle later, read or not.
  // Its current limit bit is live as well, unlike the reserved bit of a buck.
  property p_lin_live;
    @(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> chan_status[NUM_BUCK][`RSF_BIT_ON] == $past(lin_on[0])
           && chan_status[NUM_BUCK][`RSF_BIT_GOOD] == $past(lin_output_good[0])
           && chan_status[NUM_BUCK][`RSF_BIT_SS_DONE] == $past(lin_ss_done[0])
           && chan_status[NUM_BUCK][`RSF_BIT_CUR_LIM] == $past(lin_current_limit[0]);
  endproperty
  a_lin_live: assert property (p_lin_live) else $error("linear live bit mismatch");

  // A set retry flag always carries the summary fault with it.
  property p_retry_fault;
    @(posedge clk_sys) disable iff (!rst_n) chan_status[0][`RSF_BIT_RETRY] |-> chan_fault[0];
  endproperty
  a_retry_fault: assert property (p_retry_fault) else $error("retry flag without fault");

  // Enabled, ramped and bad output raises the second linear fault.
  property p_lin2_fault;
    @(posedge clk_sys) disable iff (!rst_n)
      lin_on[1] && lin_ss_done[1] && !lin_output_good[1] |=> chan_fault[NUM_BUCK+1];
  endproperty
  a_lin2_fault: assert property (p_lin2_fault) else $error("second linear fault not set");

  // A bad output before the ramp has finished is not a fault yet.
  // This keeps the normal start-up droop from raising a false interrupt.
  property p_lin2_ramp;
    @(posedge clk_sys) disable iff (!rst_n)
      !lin_ss_done[1] && !chan_fault[NUM_BUCK+1] |=> !chan_fault[NUM_BUCK+1];
  endproperty
  a_lin2_ramp: assert property (p_lin2_ramp) else $error("linear fault set during ramp");

  // A read with the output good again returns the fault flag, then clears both buck flags.
  // Retry cannot re-arm here, because its cause needs the output to be bad.
  sequence s_buck_read_good;
    rd_req && rd_addr == `RSF_ADDR_BUCK3 && chan_fault[0] && buck_output_good[0];
  endsequence
  sequence s_buck_cleared;
    ##1 !chan_fault[0] && !chan_status[0][`RSF_BIT_RETRY] && rd_data[`RSF_BIT_FAULT];
  endsequence
  property p_buck_clear;
    @(posedge clk_sys) disable iff (!rst_n) s_buck_read_good |-> s_buck_cleared;
  endproperty
  a_buck_clear: assert property (p_buck_clear) else $error("buck flags not cleared by read");

  // Without a read a sticky flag stays, even when its cause has gone.
  // The fault bit of the first buck stands for all sticky bits here.
  property p_buck_hold;
    @(posedge clk_sys) disable iff (!rst_n) chan_fault[0] && !chan_clear[0] |=> chan_fault[0];
  endproperty
  a_buck_hold: assert property (p_buck_hold) else $error("buck fault cleared itself");

  // The same holds for the second linear channel.
  property p_lin2_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      chan_fault[NUM_BUCK+1] && !chan_clear[NUM_BUCK+1] |=> chan_fault[NUM_BUCK+1];
  endproperty
  a_lin2_hold: assert property (p_lin2_hold) else $error("linear fault cleared itself");

  // Reading the second buck with its comparator quiet drops the negative limit flag.
  property p_neg_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_req && rd_addr == `RSF_ADDR_BUCK4 && !buck_neg_limit_cmp[1] |=> !chan_status[1][`RSF_BIT_NEG];
  endproperty
  a_neg_clear: assert property (p_neg_clear) else $error("negative limit flag kept after read");
endmodule : rsf_status_bank

// ### src/rsf_defines.svh
// Constants for the regulator status flag bank: offsets, bit positions, reset values and counts.
`ifndef RSF_DEFINES_SVH
`define RSF_DEFINES_SVH

// ****************************************************************
// Register offsets on the serial management port.
// ****************************************************************
`define RSF_ADDR_W 8
`define RSF_ADDR_BUCK3 8'h07
`define RSF_ADDR_BUCK4 8'h08
`define RSF_ADDR_LIN1 8'h09
`define RSF_ADDR_LIN2 8'h0a

// ****************************************************************
// Field positions inside every status byte.
// ****************************************************************
`define RSF_BIT_FAULT 7
`define RSF_BIT_RETRY 6
`define RSF_BIT_NEG 5
`define RSF_BIT_ZC 4
`define RSF_BIT_CUR_LIM 3
`define RSF_BIT_SS_DONE 2
`define RSF_BIT_GOOD 1
`define RSF_BIT_ON 0

// ****************************************************************
// Reset values and counts.
// ****************************************************************
`define RSF_STATUS_RESET 8'h00
`define RSF_READ_ZERO 8'h00
`define RSF_VALID_IDLE 1'b0
`define RSF_IRQ_IDLE 1'b1
`define RSF_OC_CNT_W 4
`define RSF_OC_CNT_ONE 4'h1
`define RSF_OC_CNT_RESET 4'h0
`define RSF_OC_LIMIT_DEFAULT 4'h8
`define RSF_NUM_BUCK 2
`define RSF_NUM_LIN 2
`define RSF_NUM_CHAN 4

`endif

// ### src/rsf_pkg.sv
// Types shared by the regulator status flag bank modules.
`include "rsf_defines.svh"
package rsf_pkg;
  // State of one switching channel: overcurrent event count and its status byte.
  typedef struct packed {
    logic [`RSF_OC_CNT_W-1:0] oc_count;
    logic [7:0] status;
  } rsf_buck_state_t;
  // State of one linear channel: its status byte.
  typedef struct packed {
    logic [7:0] status;
  } rsf_lin_state_t;
  // State of the top: read answer and interrupt line.
  typedef struct packed {
    logic [7:0] rd_data;
    logic rd_valid;
    logic irq_out_n;
  } rsf_top_state_t;
endpackage : rsf_pkg

// ### src/rsf_buck_channel.sv
// Status byte of one switching regulator channel with its sticky flags.
`timescale 1ns/1ps
`include "rsf_defines.svh"
module rsf_buck_channel
  import rsf_pkg::*;
#(
  parameter logic [`RSF_OC_CNT_W-1:0] OC_LIMIT = `RSF_OC_LIMIT_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic regulator_on_status,
  input wire logic soft_start_complete,
  input wire logic output_good,
  input wire logic highside_overcurrent_event,
  input wire logic neg_limit_cmp,
  input wire logic pulse_skip_mode,
  input wire logic zero_cross_cmp,
  input wire logic clear_on_read,
  output logic [7:0] status
);
  rsf_buck_state_t st; // Registered state.
  rsf_buck_state_t next_st; // Next state.
  logic retry_cause; // Overcurrent limit reached while the output is bad.
  logic neg_cause; // Negative limit comparator active.
  logic zc_cause; // Zero-cross detection active and tripped.
  logic next_retry; // Retry flag after this edge.
  logic fault_cause; // Live reason for the summary fault.

  // ****************************************************************
  // Flag and counter update.
  // ****************************************************************
  // A sticky flag keeps its cause ORed in, so a set in the clearing cycle wins.
  always_comb begin
    next_st = st;
    retry_cause = (st.oc_count == OC_LIMIT) && !output_good;
    neg_cause = neg_limit_cmp;
    zc_cause = pulse_skip_mode && zero_cross_cmp;
    // The count restarts once the output is good again; it saturates at the limit.
    if (output_good) begin
      next_st.oc_count = `RSF_OC_CNT_RESET;
    end else if (highside_overcurrent_event && st.oc_count != OC_LIMIT) begin
      next_st.oc_count = st.oc_count + `RSF_OC_CNT_ONE;
    end
    next_retry = retry_cause | (st.status[`RSF_BIT_RETRY] & ~clear_on_read);
    fault_cause = next_retry | (regulator_on_status & soft_start_complete & ~output_good);
    next_st.status[`RSF_BIT_FAULT] = fault_cause | (st.status[`RSF_BIT_FAULT] & ~clear_on_read);
    next_st.status[`RSF_BIT_RETRY] = next_retry;
    next_st.status[`RSF_BIT_NEG] = neg_cause | (st.status[`RSF_BIT_NEG] & ~clear_on_read);
    next_st.status[`RSF_BIT_ZC] = zc_cause | (st.status[`RSF_BIT_ZC] & ~clear_on_read);
    next_st.status[`RSF_BIT_CUR_LIM] = 1'b0;
    next_st.status[`RSF_BIT_SS_DONE] = soft_start_complete;
    next_st.status[`RSF_BIT_GOOD] = output_good;
    next_st.status[`RSF_BIT_ON] = regulator_on_status;
  end

  // Register the state; power-on clears every flag.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{oc_count: `RSF_OC_CNT_RESET, status: `RSF_STATUS_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign status = st.status;

  // A read must not drop a flag while its cause is still there.
  property p_neg_held;
    @(posedge clk_sys) disable iff (!rst_n) neg_limit_cmp |=> status[`RSF_BIT_NEG];
  endproperty
  a_neg_held: assert property (p_neg_held) else $error("negative limit flag lost");
  // Zero-cross flag only rises when detection is active and the comparator trips.
  property p_zc_cause;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(status[`RSF_BIT_ZC]) |-> $past(pulse_skip_mode) && $past(zero_cross_cmp);
  endproperty
  a_zc_cause: assert property (p_zc_cause) else $error("zero-cross flag set without cause");
endmodule : rsf_buck_channel

// ### src/rsf_lin_channel.sv
// Status byte of one linear regulator channel with its sticky fault flag.
`timescale 1ns/1ps
`include "rsf_defines.svh"
module rsf_lin_channel
  import rsf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic regulator_on_status,
  input wire logic soft_start_complete,
  input wire logic output_good,
  input wire logic current_limit_live,
  input wire logic clear_on_read,
  output logic [7:0] status
);
  rsf_lin_state_t st; // Registered state.
  rsf_lin_state_t next_st; // Next state.
  logic fault_cause; // Enabled, ramp done and output bad.

  // ****************************************************************
  // Status update.
  // ****************************************************************
  // Reserved bits are rebuilt as zero on every edge; nothing writes them.
  always_comb begin
    next_st.status = `RSF_STATUS_RESET;
    fault_cause = regulator_on_status & soft_start_complete & ~output_good;
    next_st.status[`RSF_BIT_FAULT] = fault_cause | (st.status[`RSF_BIT_FAULT] & ~clear_on_read);
    next_st.status[`RSF_BIT_CUR_LIM] = current_limit_live;
    next_st.status[`RSF_BIT_SS_DONE] = soft_start_complete;
    next_st.status[`RSF_BIT_GOOD] = output_good;
    next_st.status[`RSF_BIT_ON] = regulator_on_status;
  end

  // Register the state; power-on clears the fault flag.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{status: `RSF_STATUS_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign status = st.status;

  // The fault flag rises only from its documented cause.
  property p_lin_fault_cause;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(status[`RSF_BIT_FAULT]) |-> $past(fault_cause);
  endproperty
  a_lin_fault_cause: assert property (p_lin_fault_cause) else $error("linear fault set without cause");
endmodule : rsf_lin_channel

// ### verif/rsf_host_model.sv
// Host processor model that issues single-byte status reads on the read port.
`timescale 1ns/1ps
module rsf_host_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] addr,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic rd_req,
  output logic [7:0] rd_addr,
  output logic [7:0] data,
  output logic done
);
  logic busy; // A read is in flight.

  // ****************************************************************
  // Read sequencer.
  // ****************************************************************
  // One strobe per read. Outside a read the address is inverted every cycle,
  // so a design that samples it late never sees a helpful stale value.
  // The host never writes, so reserved positions only ever see zeros.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_req <= 1'b0;
      rd_addr <= 8'h00;
      busy <= 1'b0;
      data <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        rd_req <= 1'b1;
        rd_addr <= addr;
        busy <= 1'b1;
      end else begin
        rd_req <= 1'b0;
        rd_addr <= ~rd_addr;
      end
      // The answer is taken at the edge where the valid pulse is seen.
      if (busy && rd_valid) begin
        data <= rd_data;
        done <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule : rsf_host_model

// ### verif/rsf_status_bank_tb_top.sv
// Self-checking bench for the regulator status flag bank.
`timescale 1ns/1ps
module rsf_status_bank_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] b_on = 2'h0, b_ss = 2'h0, b_good = 2'h0, b_oc = 2'h0, b_neg = 2'h0, b_psk = 2'h0, b_zc = 2'h0;
  logic [1:0] l_on = 2'h0, l_ss = 2'h0, l_good = 2'h0, l_climit = 2'h0;
  logic [3:0] mask = 4'hf; // All faults masked until a test opens them.
  logic start = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd_req, rd_valid, irq_out_n, done;
  logic [7:0] rd_addr, rd_data, data;
  int checks = 0;
  int bad_count = 0;
  int j;

  // A small limit keeps the overcurrent count short.
  rsf_status_bank #(.NUM_BUCK(2), .NUM_LIN(2), .OC_LIMIT(4'h2)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .rd_req(rd_req), .rd_addr(rd_addr),
    .buck_on(b_on), .buck_ss_done(b_ss), .buck_output_good(b_good), .buck_overcurrent_event(b_oc),
    .buck_neg_limit_cmp(b_neg), .buck_pulse_skip_mode(b_psk), .buck_zero_cross_cmp(b_zc),
    .lin_on(l_on), .lin_ss_done(l_ss), .lin_output_good(l_good), .lin_current_limit(l_climit),
    .fault_irq_mask(mask), .rd_data(rd_data), .rd_valid(rd_valid), .irq_out_n(irq_out_n));

  rsf_host_model host (
    .clk_sys(clk_sys), .rst_n(rst_n), .start(start), .addr(addr), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_req(rd_req), .rd_addr(rd_addr), .data(data), .done(done));

  // 50 MHz clock.
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // One read through the host; a missing answer ends the run.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int i;
    i = 0;
    @(posedge clk_sys);
    start <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    start <= 1'b0;
    while (done !== 1'b1) begin
      @(negedge clk_sys);
      i++;
      if (i > 8) begin
        bad_count++;
        conclude();
      end
    end
    check($sformatf("status %h", a), data, exp);
  endtask : rd

  // Live inputs of all channels, changed together at one rising edge, then left to settle.
  task automatic set_live(input logic [1:0] bo, bs, bp, lo, ls, lp, li);
    @(posedge clk_sys);
    b_on <= bo;
    b_ss <= bs;
    b_good <= bp;
    l_on <= lo;
    l_ss <= ls;
    l_good <= lp;
    l_climit <= li;
    repeat (2) @(posedge clk_sys);
  endtask : set_live

  // The interrupt line is looked at mid-cycle, after the edge's updates.
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("irq_out_n", {7'h00, irq_out_n}, {7'h00, e});
  endtask : irq_is

  // The mask changes at a rising edge, as every other input does.
  task automatic set_mask(input logic [3:0] m);
    @(posedge clk_sys);
    mask <= m;
  endtask : set_mask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    irq_is(1'b1);
    for (j = 0; j < 5; j++) rd(8'(8'h07 + j), 8'h00);
    $display("test reset values done");
    set_live(2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3);
    for (j = 0; j < 8; j++) rd(8'(8'h07 + j / 2), (j < 4) ? 8'h07 : 8'h0f);
    set_live(2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1);
    rd(8'h09, 8'h08);
    rd(8'h07, 8'h00);
    $display("test live bits done");
    // Enabled but still ramping: no fault yet.
    set_live(2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h0, 2'h0);
    rd(8'h0a, 8'h01);
    set_live(2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h0);
    irq_is(1'b1);
    set_mask(4'h0);
    irq_is(1'b0);
    rd(8'h0a, 8'h85);
    rd(8'h0a, 8'h85);
    set_live(2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h0);
    rd(8'h0a, 8'h87);
    rd(8'h0a, 8'h07);
    irq_is(1'b1);
    set_live(2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
    rd(8'h07, 8'h85);
    set_mask(4'h1);
    irq_is(1'b1);
    set_mask(4'h0);
    irq_is(1'b0);
    set_live(2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
    rd(8'h07, 8'h80);
    rd(8'h07, 8'h00);
    $display("test fault and interrupt done");
    @(posedge clk_sys);
    b_neg <= 2'h2;
    @(posedge clk_sys);
    b_neg <= 2'h0;
    rd(8'h08, 8'h20);
    rd(8'h08, 8'h00);
    @(posedge clk_sys);
    b_zc <= 2'h2;
    rd(8'h08, 8'h00);
    @(posedge clk_sys);
    b_psk <= 2'h2;
    @(posedge clk_sys);
    b_zc <= 2'h0;
    b_psk <= 2'h0;
    rd(8'h08, 8'h10);
    rd(8'h08, 8'h00);
    $display("test event flags done");
    // Two overcurrent events with the output low reach the limit of two.
    for (j = 0; j < 2; j++) begin
      @(posedge clk_sys);
      b_oc <= 2'h1;
      @(posedge clk_sys);
      b_oc <= 2'h0;
      rd(8'h07, (j == 0) ? 8'h00 : 8'hc0);
    end
    rd(8'h07, 8'hc0);
    irq_is(1'b0);
    set_live(2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0);
    rd(8'h07, 8'hc2);
    rd(8'h07, 8'h02);
    $display("test retry flag done");
    conclude();
  end
endmodule : rsf_status_bank_tb_top
